// >>> core/asram_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Controller never drives against reading memory
// - Select low at least 7 ns before end
// - Address stable 7 ns before write end
// - Write interval 7 ns with drive high
// - Write interval 10 ns with drive low
// - Write data valid 5 ns before end
// - Data held until write interval ends
// - Address valid at write interval start
// - Address unchanged until write interval ends
module asram_ctrl (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire asram_pkg::asram_req_t req,
  input wire logic req_valid,
  output logic req_ready,
  output logic [asram_pkg::DATA_W-1:0] rdata,
  output logic rdata_valid,
  output asram_pkg::asram_pins_t pins,
  input wire logic [asram_pkg::DATA_W-1:0] data_in,
  output logic [asram_pkg::DATA_W-1:0] data_out,
  output logic [asram_pkg::DATA_W-1:0] data_oe
);
  asram_pkg::asram_state_t state_reg; // Sequencer state
  logic [asram_pkg::CNT_W-1:0] cnt_reg; // Phase cycle counter
  logic [asram_pkg::LANES-1:0] lane_reg; // Lanes of current access
  logic [asram_pkg::DATA_W-1:0] data_sync; // Pin data after two flops
  logic [asram_pkg::DATA_W-1:0] lane_mask; // Per-bit lane enable
  logic cnt_done; // Phase count reached

  // Pin data crosses two flops before capture
  asram_sync #(
    .W(asram_pkg::DATA_W)
  ) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .d(data_in),
    .q(data_sync)
  );

  // Expand lane enables to bit enables
  generate
    for (genvar g = 0; g < asram_pkg::DATA_W; g++) begin : g_lane
      assign lane_mask[g] = lane_reg[g / asram_pkg::LANE_W];
    end
  endgenerate

  assign cnt_done = (cnt_reg == '0);

  // Sequencer; each timed phase ends when its counter runs out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= asram_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        asram_pkg::ST_IDLE: begin
          // Accept a request
          if (req_valid) begin
            state_reg <= req.write ? asram_pkg::ST_WSETUP : asram_pkg::ST_RACT;
          end
        end
        asram_pkg::ST_WSETUP: state_reg <= asram_pkg::ST_WPULSE;
        asram_pkg::ST_WPULSE: begin
          if (cnt_done) begin
            state_reg <= asram_pkg::ST_WEND;
          end
        end
        asram_pkg::ST_WEND: state_reg <= asram_pkg::ST_GAP;
        asram_pkg::ST_RACT: begin
          if (cnt_done) begin
            state_reg <= asram_pkg::ST_RCAP;
          end
        end
        asram_pkg::ST_RCAP: state_reg <= asram_pkg::ST_GAP;
        asram_pkg::ST_GAP: begin
          if (cnt_done) begin
            state_reg <= asram_pkg::ST_IDLE;
          end
        end
        default: state_reg <= asram_pkg::ST_IDLE;
      endcase
    end
  end

  // Phase counter loaded on entry to each timed phase
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= '0;
    end else begin
      case (state_reg)
        asram_pkg::ST_IDLE: begin
          // Read waits select-to-data plus the two sync flops
          cnt_reg <= asram_pkg::CNT_W'(asram_pkg::RD_CYC + 1);
        end
        asram_pkg::ST_WSETUP: cnt_reg <= asram_pkg::CNT_W'(asram_pkg::WR_CYC - 1);
        asram_pkg::ST_WEND, asram_pkg::ST_RCAP: begin
          cnt_reg <= asram_pkg::CNT_W'(asram_pkg::GAP_CYC - 1);
        end
        default: begin
          if (!cnt_done) begin
            cnt_reg <= cnt_reg - 1'b1;
          end
        end
      endcase
    end
  end

  // Latch lanes and write data; held stable across the whole access
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      lane_reg <= '0;
      data_out <= asram_pkg::DATA_RST;
    end else if (state_reg == asram_pkg::ST_IDLE && req_valid) begin
      lane_reg <= req.lane_en;
      data_out <= req.wdata;
    end
  end

  // Pin outputs in one process; select and strobe fall together, output drive stays high on writes
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pins.word_address <= asram_pkg::ADDR_RST;
      pins.chip_select_n <= 1'b1;
      pins.write_strobe_n <= 1'b1;
      pins.output_drive_n <= 1'b1;
      pins.low_lane_mask_n <= 1'b1;
      pins.high_lane_mask_n <= 1'b1;
    end else begin
      case (state_reg)
        asram_pkg::ST_WSETUP: begin
          pins.chip_select_n <= 1'b0;
          pins.write_strobe_n <= 1'b0;
          pins.output_drive_n <= 1'b1;
          pins.low_lane_mask_n <= ~lane_reg[0];
          pins.high_lane_mask_n <= ~lane_reg[1];
        end
        asram_pkg::ST_IDLE: begin
          // Address set a cycle ahead of any write strobe
          if (req_valid) begin
            pins.word_address <= req.addr;
          end
          if (req_valid && !req.write) begin
            pins.chip_select_n <= 1'b0;
            pins.output_drive_n <= 1'b0;
            pins.low_lane_mask_n <= ~req.lane_en[0];
            pins.high_lane_mask_n <= ~req.lane_en[1];
          end
        end
        asram_pkg::ST_WPULSE: begin
          if (cnt_done) begin
            pins.write_strobe_n <= 1'b1;
            pins.chip_select_n <= 1'b1;
          end
        end
        asram_pkg::ST_RCAP: begin
          pins.chip_select_n <= 1'b1;
          pins.output_drive_n <= 1'b1;
        end
        asram_pkg::ST_GAP: begin
          pins.low_lane_mask_n <= 1'b1;
          pins.high_lane_mask_n <= 1'b1;
        end
        default: begin
          pins.chip_select_n <= pins.chip_select_n;
        end
      endcase
    end
  end

  // Data drive only while strobe is low plus one end cycle for hold
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      data_oe <= '0;
    end else if (state_reg == asram_pkg::ST_WSETUP) begin
      data_oe <= lane_mask;
    end else if (state_reg == asram_pkg::ST_WEND) begin
      data_oe <= '0;
    end else if (state_reg != asram_pkg::ST_WPULSE) begin
      data_oe <= '0;
    end
  end

  // Read capture, lanes not enabled read zero
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= asram_pkg::DATA_RST;
      rdata_valid <= 1'b0;
    end else begin
      rdata_valid <= (state_reg == asram_pkg::ST_RACT) && cnt_done;
      if (state_reg == asram_pkg::ST_RACT && cnt_done) begin
        rdata <= data_sync & lane_mask;
      end
    end
  end

  // Ready only when idle and not about to start
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_reg == asram_pkg::ST_GAP && cnt_done) ||
                   (state_reg == asram_pkg::ST_IDLE && !req_valid);
    end
  end
endmodule // asram_ctrl

// >>> core/asram_pkg.sv
package asram_pkg;
  // Memory geometry
  localparam int unsigned ADDR_W = 18;
  localparam int unsigned DATA_W = 16;
  localparam int unsigned LANE_W = 8;
  localparam int unsigned LANES = 2;
  // Clock period in picoseconds
  localparam int unsigned CLK_PERIOD_PS = 100000;
  // Timing figures in ns as printed
  localparam int unsigned T_WRITE_WIDTH_DRIVE_HIGH_NS = 7;
  localparam int unsigned T_WRITE_INTERVAL_WIDTH_DRIVE_LOW_NS = 10;
  localparam int unsigned T_ADDRESS_TO_WRITE_END_NS = 7;
  localparam int unsigned T_DATA_TO_WRITE_END_NS = 5;
  localparam int unsigned T_SELECT_TO_VALID_DATA_NS = 10;
  localparam int unsigned T_DRIVE_TO_VALID_DATA_NS = 5;
  localparam int unsigned T_WRITE_TO_FLOAT_NS = 5;
  localparam int unsigned T_READ_CYCLE_TIME_NS = 10;
  // Least times round up, never below one cycle
  function automatic int unsigned ns_to_cycles(input int unsigned ns);
    int unsigned c;
    c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int unsigned WR_CYC = ns_to_cycles(T_WRITE_INTERVAL_WIDTH_DRIVE_LOW_NS);
  localparam int unsigned RD_CYC = ns_to_cycles(T_SELECT_TO_VALID_DATA_NS);
  localparam int unsigned FLOAT_CYC = ns_to_cycles(T_WRITE_TO_FLOAT_NS);
  localparam int unsigned GAP_CYC = ns_to_cycles(T_READ_CYCLE_TIME_NS);
  localparam int unsigned CNT_W = 4;
  // Idle pin values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [17:0] ADDR_RST = 18'h0_0000;

  // User request bundle
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [LANES-1:0] lane_en;
  } asram_req_t;

  // Pin bundle driven toward the memory
  typedef struct packed {
    logic chip_select_n;
    logic write_strobe_n;
    logic output_drive_n;
    logic low_lane_mask_n;
    logic high_lane_mask_n;
    logic [ADDR_W-1:0] word_address;
  } asram_pins_t;

  // Controller states, Gray coded from IDLE to WEND and from RACT to GAP
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_WSETUP = 3'b001,
    ST_WPULSE = 3'b011,
    ST_WEND = 3'b010,
    ST_RACT = 3'b110,
    ST_RCAP = 3'b111,
    ST_GAP = 3'b101
  } asram_state_t;
endpackage

// >>> core/asram_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of pin inputs
module asram_sync #(
  parameter int unsigned W = 16
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_reg; // First stage, read only by the second

  // Two flops in series
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q <= '0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // asram_sync

// >>> bench/asram_mem_model.sv
`timescale 1ns/1ps
// Behavioural memory seen from the pins
module asram_mem_model (
  input wire asram_pkg::asram_pins_t pins,
  input wire logic [15:0] wire_val,
  output logic [15:0] q,
  output logic [15:0] q_oe
);
  logic [15:0] mem [0:262143]; // Static store, no refresh
  logic wr_act; // Write interval open
  logic rd_en; // Read mode with outputs on
  assign wr_act = !pins.chip_select_n && !pins.write_strobe_n;
  // Lanes follow the wire while the interval is open
  always @* begin
    if (wr_act && !pins.low_lane_mask_n) mem[pins.word_address][7:0] = wire_val[7:0];
    if (wr_act && !pins.high_lane_mask_n) mem[pins.word_address][15:8] = wire_val[15:8];
  end
  // Strobe low or deselect floats the lines at once
  assign rd_en = !pins.chip_select_n && pins.write_strobe_n && !pins.output_drive_n;
  assign q = mem[pins.word_address];
  assign q_oe = {{8{rd_en && !pins.high_lane_mask_n}}, {8{rd_en && !pins.low_lane_mask_n}}};
endmodule // asram_mem_model

// >>> bench/asram_ctrl_checker.sv
`timescale 1ns/1ps
// Pin timing checks on the controller
module asram_ctrl_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire asram_pkg::asram_req_t req,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire logic [15:0] rdata,
  input wire logic rdata_valid,
  input wire asram_pkg::asram_pins_t pins,
  input wire logic [15:0] data_in,
  input wire logic [15:0] data_out,
  input wire logic [15:0] data_oe
);
  logic wr_act; // Write interval open
  assign wr_act = !pins.chip_select_n && !pins.write_strobe_n;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  no_contention_a: assert property (!pins.output_drive_n |-> data_oe == 16'h0000 && pins.write_strobe_n)
    else $error("controller drives while memory reads");
  addr_hold_a: assert property ((wr_act || $fell(wr_act)) |-> $stable(pins.word_address))
    else $error("address moved inside write");
  data_hold_a: assert property (wr_act |-> $stable(data_out))
    else $error("write data moved inside write");
  lane_drive_a: assert property (wr_act |-> data_oe == {{8{!pins.high_lane_mask_n}}, {8{!pins.low_lane_mask_n}}})
    else $error("driven lanes differ from masks");
  tail_hold_a: assert property ($fell(wr_act) |-> $stable(data_oe) && $stable(data_out))
    else $error("data dropped at write end");
  cs_lead_a: assert property ($fell(wr_act) |-> $past(pins.chip_select_n) == 1'b0 && pins.output_drive_n && $past(pins.output_drive_n))
    else $error("select not low before write end");
  gap_a: assert property ($rose(pins.chip_select_n) |=> pins.chip_select_n)
    else $error("accesses not spaced");
  read_lat_a: assert property (req_valid && req_ready && !req.write |-> ##4 rdata_valid)
    else $error("read answer late");
  cover property (rdata_valid);
  cover property ($fell(wr_act));
  cover property (wr_act && pins.high_lane_mask_n);
endmodule // asram_ctrl_checker

// >>> bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  logic ref_clk = 1'b0; // Ten megahertz clock
  logic rst_n = 1'b0; // Reset held at start
  asram_pkg::asram_req_t req = '0;
  logic req_valid = 1'b0;
  logic req_ready, rdata_valid;
  logic [15:0] rdata, data_in, data_out, data_oe, q, q_oe;
  logic [15:0] last_v = 16'h0000; // Last wire value, floats to inverse
  asram_pkg::asram_pins_t pins;
  int failures = 0;
  int comparisons = 0;
  always #50 ref_clk = ~ref_clk;
  // Wire: controller, then memory, else floating
  assign data_in = (data_oe & data_out) | (~data_oe & q_oe & q) | (~data_oe & ~q_oe & ~last_v);
  always @(posedge ref_clk) last_v <= data_in;
  asram_ctrl u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid), .req_ready(req_ready),
    .rdata(rdata), .rdata_valid(rdata_valid), .pins(pins), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));
  asram_mem_model u_mem (.pins(pins), .wire_val(data_in), .q(q), .q_oe(q_oe));
  task automatic end_sim;
    $display("failures=%0d comparisons=%0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One request, taken when idle
  task automatic access(input logic wr, input logic [17:0] a, input logic [15:0] d, input logic [1:0] ln);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 100) begin @(posedge ref_clk); #5; n++; end
    if (n >= 100) begin failures++; end_sim; end
    req = '{write: wr, addr: a, wdata: d, lane_en: ln};
    req_valid = 1'b1;
    @(posedge ref_clk);
    #5 req_valid = 1'b0;
  endtask
  // Read and compare the returned word
  task automatic rd(input logic [17:0] a, input logic [1:0] ln, input logic [15:0] exp);
    int n;
    n = 0;
    access(1'b0, a, 16'h0000, ln);
    while (rdata_valid !== 1'b1 && n < 40) begin @(posedge ref_clk); #5; n++; end
    if (n >= 40) begin failures++; end_sim; end
    check(rdata, exp);
  endtask
  task automatic t_full_word;
    access(1'b1, 18'h0_0005, 16'h1234, 2'b11);
    rd(18'h0_0005, 2'b11, 16'h1234);
  endtask
  task automatic t_byte_lanes;
    access(1'b1, 18'h0_0005, 16'hffcd, 2'b01);
    rd(18'h0_0005, 2'b11, 16'h12cd);
    access(1'b1, 18'h0_0005, 16'hab77, 2'b10);
    rd(18'h0_0005, 2'b11, 16'habcd);
    rd(18'h0_0005, 2'b10, 16'hab00);
    rd(18'h0_0005, 2'b01, 16'h00cd);
  endtask
  task automatic t_address_ends;
    access(1'b1, 18'h3_ffff, 16'h5a5a, 2'b11);
    access(1'b1, 18'h0_0000, 16'ha5a5, 2'b11);
    rd(18'h3_ffff, 2'b11, 16'h5a5a);
    rd(18'h0_0000, 2'b11, 16'ha5a5);
  endtask
  initial begin
    repeat (10) @(posedge ref_clk);
    #5 rst_n = 1'b1;
    t_full_word();
    t_byte_lanes();
    t_address_ends();
    end_sim();
  end
endmodule // testbench
bind asram_ctrl asram_ctrl_checker u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_valid(req_valid),
  .req_ready(req_ready), .rdata(rdata), .rdata_valid(rdata_valid), .pins(pins), .data_in(data_in),
  .data_out(data_out), .data_oe(data_oe));
